// *** src/dbp_pkg.sv ***
// Constants for the dual byte bidirectional port block
// Assumes a data-memory style CPU bus with 8-bit addresses
`default_nettype none
package dbp_pkg;
  // ==========================================
  // Register locations
  localparam logic [7:0] DBP_ADDR_FIRST_DATA = 8'h12;
  localparam logic [7:0] DBP_ADDR_FIRST_DIR = 8'h13;
  localparam logic [7:0] DBP_ADDR_SECOND_DATA = 8'h14;
  localparam logic [7:0] DBP_ADDR_SECOND_DIR = 8'h15;
  // ==========================================
  // Values after reset
  localparam logic [7:0] DBP_RST_DATA = 8'hff;
  localparam logic [7:0] DBP_RST_DIR = 8'hff;
  localparam logic [7:0] DBP_RST_RDATA = 8'h00;
  localparam logic [7:0] DBP_RST_EDGE = 8'hff;
  // ==========================================
  // Bit set/clear and byte complement operation codes
  typedef enum logic [1:0] {
    DBP_OP_SET = 2'b00,
    DBP_OP_CLR = 2'b01,
    DBP_OP_CPL = 2'b10
  } dbp_bitop_t;
endpackage : dbp_pkg
`default_nettype wire

// *** src/dbp_port.sv ***
// Two 8-bit bidirectional ports with latches, direction bits and wake-up
// Assumes CPU strobes are one clock long and pins are synchronous to clk
//
// What this block does
// - Sixteen lines, data latches at 12H, 14H
// - Reads of input lines return live pins, no input latch
// - Written latch value holds until rewritten
// - Per-line direction: 1 input, 0 push-pull
// - Read gives pad if input, latch if output
// - Direction registers live at 13H and 15H
// - Power-on, pin, normal watchdog reset: all ones
// - Watchdog time-out while halted changes nothing
// - Bit set/clear on either port latch
// - Read-modify-write reads all eight line states
// - First port wake-up fixed by factory option
// - Pull-high option applies to all lines
`timescale 1ns/1ps
`default_nettype none
module dbp_port #(
  parameter bit WAKE_OPTION = 1'b1,
  parameter bit PULL_OPTION = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wdt_timeout,
  input wire logic halted,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic bit_en,
  input wire dbp_pkg::dbp_bitop_t bit_op,
  input wire logic [2:0] bit_sel,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pull_en,
  output logic wake
);
  import dbp_pkg::*;

  logic [7:0] first_port_data_q;
  logic [7:0] first_port_direction_q;
  logic [7:0] second_port_data_q;
  logic [7:0] second_port_direction_q;
  logic [7:0] first_in_prev_q;
  logic [7:0] rd_data_q;
  logic port_reset;
  logic [7:0] view_first;
  logic [7:0] view_second;
  logic [7:0] bit_mask;
  logic [7:0] rmw_first;
  logic [7:0] rmw_second;

  // ==========================================
  // Read view of each port
  function automatic logic [7:0] line_view(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pad);
    line_view = (dir & pad) | (~dir & lat);
  endfunction : line_view

  function automatic logic [7:0] apply_op(input logic [7:0] val, input logic [7:0] mask,
                                          input dbp_bitop_t op);
    unique case (op)
      DBP_OP_SET: apply_op = val | mask;
      DBP_OP_CLR: apply_op = val & ~mask;
      DBP_OP_CPL: apply_op = ~val;
      default: apply_op = val;
    endcase
  endfunction : apply_op

  assign view_first = line_view(first_port_direction_q, first_port_data_q, pin_in[7:0]);
  assign view_second = line_view(second_port_direction_q, second_port_data_q, pin_in[15:8]);
  assign bit_mask = 8'h01 << bit_sel;
  assign rmw_first = apply_op(view_first, bit_mask, bit_op);
  assign rmw_second = apply_op(view_second, bit_mask, bit_op);

  // Watchdog reset only counts while running
  assign port_reset = !rst_b || (wdt_timeout && !halted);

  // ==========================================
  // First port registers
  always_ff @(posedge clk) begin
    if (port_reset) begin
      first_port_data_q <= DBP_RST_DATA;
      first_port_direction_q <= DBP_RST_DIR;
    end else begin
      if (wr_en && addr == DBP_ADDR_FIRST_DATA) begin
        first_port_data_q <= wr_data;
      end else if (bit_en && addr == DBP_ADDR_FIRST_DATA) begin
        first_port_data_q <= rmw_first;
      end
      if (wr_en && addr == DBP_ADDR_FIRST_DIR) begin
        first_port_direction_q <= wr_data;
      end
    end
  end

  // ==========================================
  // Second port registers
  always_ff @(posedge clk) begin
    if (port_reset) begin
      second_port_data_q <= DBP_RST_DATA;
      second_port_direction_q <= DBP_RST_DIR;
    end else begin
      if (wr_en && addr == DBP_ADDR_SECOND_DATA) begin
        second_port_data_q <= wr_data;
      end else if (bit_en && addr == DBP_ADDR_SECOND_DATA) begin
        second_port_data_q <= rmw_second;
      end
      if (wr_en && addr == DBP_ADDR_SECOND_DIR) begin
        second_port_direction_q <= wr_data;
      end
    end
  end

  // ==========================================
  // Read data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_q <= DBP_RST_RDATA;
    end else if (rd_en) begin
      unique case (addr)
        DBP_ADDR_FIRST_DATA: rd_data_q <= view_first;
        DBP_ADDR_FIRST_DIR: rd_data_q <= first_port_direction_q;
        DBP_ADDR_SECOND_DATA: rd_data_q <= view_second;
        DBP_ADDR_SECOND_DIR: rd_data_q <= second_port_direction_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end
  assign rd_data = rd_data_q;

  // ==========================================
  // Pins
  assign pin_out = {second_port_data_q, first_port_data_q};
  assign pin_oe = ~{second_port_direction_q, first_port_direction_q};
  assign pull_en = PULL_OPTION ? 16'hffff : 16'h0000;

  // ==========================================
  // Wake-up
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_in_prev_q <= DBP_RST_EDGE;
    end else begin
      first_in_prev_q <= pin_in[7:0];
    end
  end
  assign wake = WAKE_OPTION && halted &&
                |(first_in_prev_q & ~pin_in[7:0] & first_port_direction_q);

  // ==========================================
  // Checks
  chk_reset_ones: assert property (@(posedge clk) !rst_b |=>
    first_port_data_q == 8'hff && second_port_direction_q == 8'hff)
    else $error("port not all ones after reset");
  chk_halt_wdt_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (wdt_timeout && halted && !wr_en && !bit_en) |=> $stable(first_port_data_q))
    else $error("halted watchdog changed latch");
  chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (!wr_en && !bit_en && !wdt_timeout) |=> $stable(second_port_data_q))
    else $error("latch changed without write");
  chk_write_store: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && addr == 8'h14 && !wdt_timeout) |=> second_port_data_q == $past(wr_data))
    else $error("second latch write lost");
  chk_dir_write: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && addr == 8'h13 && !wdt_timeout) |=> first_port_direction_q == $past(wr_data))
    else $error("first direction write lost");
  chk_read_view: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_en && addr == 8'h12) |=> rd_data == (($past(first_port_direction_q) & $past(pin_in[7:0]))
    | (~$past(first_port_direction_q) & $past(first_port_data_q))))
    else $error("first port read mismatch");
  chk_drive_dir: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && addr == DBP_ADDR_SECOND_DIR && !wdt_timeout)
    |=> pin_oe[15:8] == ~$past(wr_data))
    else $error("drive enable mismatch");
  chk_bit_set: assert property (@(posedge clk) disable iff (!rst_b)
    (bit_en && !wr_en && bit_op == DBP_OP_SET && addr == 8'h12 && !wdt_timeout)
    |=> first_port_data_q[$past(bit_sel)])
    else $error("bit set failed");
  chk_wake_run: assert property (@(posedge clk) !halted |-> !wake)
    else $error("wake while running");

  // ==========================================
  // Checks: more register writes
  chk_first_write: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && addr == DBP_ADDR_FIRST_DATA && !wdt_timeout)
    |=> first_port_data_q == $past(wr_data))
    else $error("first latch write lost");
  chk_second_dir: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && addr == DBP_ADDR_SECOND_DIR && !wdt_timeout)
    |=> second_port_direction_q == $past(wr_data))
    else $error("second direction write lost");
  chk_bit_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (bit_en && !wr_en && bit_op == DBP_OP_CLR && addr == DBP_ADDR_FIRST_DATA && !wdt_timeout)
    |=> !first_port_data_q[$past(bit_sel)])
    else $error("bit clear failed");
  chk_cpl_byte: assert property (@(posedge clk) disable iff (!rst_b)
    (bit_en && !wr_en && bit_op == DBP_OP_CPL && addr == DBP_ADDR_SECOND_DATA && !wdt_timeout)
    |=> second_port_data_q == ~(($past(second_port_direction_q) & $past(pin_in[15:8]))
    | (~$past(second_port_direction_q) & $past(second_port_data_q))))
    else $error("byte complement failed");

  // ==========================================
  // Checks: reset, watchdog, read data and wake
  chk_wdt_run_reset: assert property (@(posedge clk) disable iff (!rst_b)
    (wdt_timeout && !halted)
    |=> first_port_direction_q == DBP_RST_DIR && second_port_data_q == DBP_RST_DATA)
    else $error("running watchdog did not reset port");
  chk_halt_dir_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (wdt_timeout && halted && !wr_en) |=> $stable(second_port_direction_q))
    else $error("halted watchdog changed direction");
  chk_second_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_en && addr == DBP_ADDR_SECOND_DATA)
    |=> rd_data == (($past(second_port_direction_q) & $past(pin_in[15:8]))
    | (~$past(second_port_direction_q) & $past(second_port_data_q))))
    else $error("second port read mismatch");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_en && (addr < DBP_ADDR_FIRST_DATA || addr > DBP_ADDR_SECOND_DIR))
    |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without read");
  chk_wake_edge: assert property (@(posedge clk) disable iff (!rst_b)
    (WAKE_OPTION && halted && |($past(pin_in[7:0]) & ~pin_in[7:0] & first_port_direction_q))
    |-> wake)
    else $error("falling input did not wake");
endmodule : dbp_port
`default_nettype wire

// *** dv/dbp_pins.sv ***
// Board-side model of the sixteen pads
// Assumes the board may drive any line that the port leaves as input
`timescale 1ns/1ps
`default_nettype none
module dbp_pins (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pull_en,
  input wire logic [15:0] board_en,
  input wire logic [15:0] board_val,
  output logic [15:0] pin_in
);
  // ==========================================
  // Pad level: port driver, board, pull-high or drift
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (board_en[i]) begin
        pin_in[i] = board_val[i];
      end else begin
        pin_in[i] = pull_en[i] | ~pin_out[i];
      end
    end
  end
endmodule : dbp_pins
`default_nettype wire

// *** dv/dual_byte_bidir_io_port_tb_top.sv ***
// Self-checking bench for the dual byte port block
// Assumes dbp_pkg, dbp_port and dbp_pins are compiled first
`timescale 1ns/1ps
`default_nettype none
module dual_byte_bidir_io_port_tb_top;
  import dbp_pkg::*;
  logic clk = 0, rst_b = 0, wdt_timeout = 0, halted = 0, wake;
  logic wr_en = 0, rd_en = 0, bit_en = 0;
  logic [7:0] addr = 0, wr_data = 0, rd_data;
  dbp_bitop_t bit_op = DBP_OP_SET;
  logic [2:0] bit_sel = 0;
  logic [15:0] pin_in, pin_out, pin_oe, pull_en, board_val = 16'hffff, board_en = 16'hffff;
  int mismatches = 0, checks = 0, cycles = 0;
  always #20 clk = ~clk;
  dbp_port dut (.clk(clk), .rst_b(rst_b), .wdt_timeout(wdt_timeout), .halted(halted),
    .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .bit_en(bit_en), .bit_op(bit_op), .bit_sel(bit_sel), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en), .wake(wake));
  dbp_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .board_en(board_en), .board_val(board_val), .pin_in(pin_in));
  // ==========================================
  // Access tasks
  task chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task op(logic [7:0] a, logic w, logic r, logic b, logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_en = w;
    rd_en = r;
    bit_en = b;
    wr_data = d;
    @(negedge clk);
    wr_en = 0;
    rd_en = 0;
    bit_en = 0;
  endtask : op
  task rd(logic [7:0] a, logic [7:0] e);
    op(a, 0, 1, 0, 8'h00);
    chk("rd_data", {8'h00, e}, {8'h00, rd_data});
  endtask : rd
  task test_done;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      test_done();
    end
  end
  // ==========================================
  // Tests
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1;
    for (int i = 0; i < 4; i++) rd(DBP_ADDR_FIRST_DATA + 8'(i), 8'hff);
    chk("pin_oe", 16'h0000, pin_oe);
    op(DBP_ADDR_FIRST_DATA, 1, 0, 0, 8'h5a);
    op(DBP_ADDR_FIRST_DIR, 1, 0, 0, 8'h0f);
    board_val = 16'hff3c;
    chk("pin_out", 16'hff5a, pin_out);
    chk("pin_oe", 16'h00f0, pin_oe);
    rd(DBP_ADDR_FIRST_DATA, 8'h5c);
    board_val = 16'hff3d;
    rd(DBP_ADDR_FIRST_DATA, 8'h5d);
    bit_op = DBP_OP_CLR;
    bit_sel = 3'd6;
    op(DBP_ADDR_FIRST_DATA, 0, 0, 1, 8'h00);
    chk("pin_out", 16'hff1d, pin_out);
    op(DBP_ADDR_SECOND_DATA, 1, 0, 0, 8'h00);
    op(DBP_ADDR_SECOND_DIR, 1, 0, 0, 8'h0f);
    bit_op = DBP_OP_SET;
    bit_sel = 3'd7;
    op(DBP_ADDR_SECOND_DATA, 0, 0, 1, 8'h00);
    chk("pin_out", 16'h8f1d, pin_out);
    bit_op = DBP_OP_CPL;
    op(DBP_ADDR_SECOND_DATA, 0, 0, 1, 8'h00);
    chk("pin_out", 16'h701d, pin_out);
    rd(DBP_ADDR_SECOND_DIR, 8'h0f);
    rd(8'h16, 8'h00);
    halted = 1;
    board_val = 16'hff39;
    #1 chk("wake", 16'h0001, {15'h0000, wake});
    @(negedge clk) wdt_timeout = 1;
    chk("wake", 16'h0000, {15'h0000, wake});
    @(negedge clk) wdt_timeout = 0;
    halted = 0;
    chk("pin_out", 16'h701d, pin_out);
    @(negedge clk) wdt_timeout = 1;
    @(negedge clk) wdt_timeout = 0;
    chk("pin_out", 16'hffff, pin_out);
    chk("pin_oe", 16'h0000, pin_oe);
    chk("pull_en", 16'hffff, pull_en);
    board_en = 16'h0000;
    rd(DBP_ADDR_SECOND_DATA, 8'hff);
    op(DBP_ADDR_FIRST_DATA, 1, 0, 0, 8'h00);
    chk("pin_out", 16'hff00, pin_out);
    @(negedge clk) rst_b = 0;
    @(negedge clk) rst_b = 1;
    chk("pin_out", 16'hffff, pin_out);
    chk("rd_data", 16'h0000, {8'h00, rd_data});
    op(DBP_ADDR_FIRST_DIR, 1, 0, 0, 8'h00);
    op(DBP_ADDR_FIRST_DATA, 1, 0, 0, 8'h00);
    bit_op = DBP_OP_SET;
    bit_sel = 3'd3;
    op(DBP_ADDR_FIRST_DATA, 0, 0, 1, 8'h00);
    chk("pin_out", 16'hff08, pin_out);
    rd(DBP_ADDR_FIRST_DATA, 8'h08);
    test_done();
  end
endmodule : dual_byte_bidir_io_port_tb_top
`default_nettype wire
